// ==== rtl/fifo_if.sv ====
// Push and pop signals between the serial port and one of its FIFOs.
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int W = 16, parameter int AW = 3);
	logic push;
	logic [W-1:0] wdata;
	logic full;
	logic pop;
	logic [W-1:0] rdata;
	logic empty;
	logic [AW:0] count;
	modport store (input push, input wdata, input pop, output full, output rdata, output empty,
		output count);
	modport user (output push, output wdata, output pop, input full, input rdata, input empty,
		input count);
endinterface
`default_nettype wire

// ==== rtl/ssp_fifo.sv ====
// Synchronous FIFO used for the transmit and receive queues.
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("FIFO depth must be a power of two of at least 2");
		end
	endgenerate
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic do_push, do_pop;
	always_comb
	begin
		do_push = port.push && !port.full;
		do_pop = port.pop && !port.empty;
		wptr_next = wptr_reg + (AW+1)'(do_push);
		rptr_next = rptr_reg + (AW+1)'(do_pop);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end
		else if (ce)
		begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (ce && do_push)
			mem[wptr_reg[AW-1:0]] <= port.wdata;
	end
	assign port.count = wptr_reg - rptr_reg;
	assign port.empty = (wptr_reg == rptr_reg);
	assign port.full = (port.count == (AW+1)'(DEPTH));
	assign port.rdata = mem[rptr_reg[AW-1:0]];
endmodule
`default_nettype wire

// ==== rtl/ssp_pkg.sv ====
// Constants and types shared by the synchronous serial port files.
package ssp_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int CMD_BITS = 8;
	localparam logic [11:0] CTRL0_OFF = 12'h000;
	localparam logic [11:0] CTRL1_OFF = 12'h004;
	localparam logic [11:0] DATA_OFF = 12'h008;
	localparam logic [11:0] STAT_OFF = 12'h00C;
	localparam logic [11:0] PRESC_OFF = 12'h010;
	localparam int LOOP_BIT = 0;
	localparam int ENABLE_BIT = 1;
	localparam int ROLE_BIT = 2;
	localparam int SOD_BIT = 3;
	localparam int DSS_LSB = 0;
	localparam int FRF_LSB = 4;
	localparam int SCR_LSB = 8;
	localparam int ST_TFE = 0;
	localparam int ST_TNF = 1;
	localparam int ST_RNE = 2;
	localparam int ST_RFF = 3;
	localparam int ST_BSY = 4;
	localparam logic [15:0] CTRL0_RST = 16'h0000;
	localparam logic [3:0] CTRL1_RST = 4'h0;
	localparam logic [7:0] PRESC_RST = 8'h00;
	localparam logic [3:0] DSS_MIN = 4'h3;
	localparam logic [1:0] FRF_THREE_WIRE = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {S_IDLE, S_SHIFT} link_state_t;
endpackage

// ==== rtl/ssp_top.sv ====
// Synchronous serial port: register slave, control bits, FIFOs and serial shifter.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Slave output disable has no effect on the transmit pin in master role.
// RQ2: Slave role with output disable set never drives the transmit pin.
// RQ3: Slave role with output disable clear drives the transmit pin during frames.
// RQ4: Role select clear means master, set means slave.
// RQ5: Software changes role select only while the port is disabled.
// RQ6: Port enable set starts serial operation, clear stops it.
// RQ7: Software clears port enable before reprogramming control registers.
// RQ8: Loopback select feeds transmit shifter output into receive shifter input.
// RQ9: Software preserves reserved control bits and ignores their read value.
// RQ10: Reading the data port returns and removes the oldest receive entry.
// RQ11: Writing the data port stores the value into the transmit FIFO.
// RQ12: Each received word is pushed into the receive FIFO; in slave role a word that ends while the FIFO is full is dropped.
// RQ13: Transmit words are taken one at a time and shifted out.
// RQ14: Upper unused transmit bits are ignored for sizes below sixteen.
// RQ15: Software right-justifies transmit words narrower than sixteen bits.
// RQ16: Received words narrower than sixteen bits are stored right-justified.
// RQ17: Three-wire format transmits only the low eight bits of each word.
// RQ18: Three-wire format receive width follows the programmed word size.
// RQ19: Disabling the port does not flush either FIFO.
// RQ20: Software may preload the transmit FIFO before enabling the port.
// RQ21: Bit rate is clock over prescale divisor times one plus clock rate.
// RQ22: Busy shows while a frame runs or transmit data waits.
// RQ23: While disabled the shifter stays idle and accepts no frames.
module ssp_top import ssp_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic frame_n_in,
	output logic frame_n_out,
	output logic frame_oe,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin_out,
	output logic serial_tx_pin_oe
);
	localparam int AW = $clog2(FIFO_DEPTH);
	fifo_if #(.W(DATA_W), .AW(AW)) tx_q();
	fifo_if #(.W(DATA_W), .AW(AW)) rx_q();
	ssp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .port(tx_q.store));
	ssp_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .port(rx_q.store));

	// Pin synchronisers: a change is accepted only once stages two and three agree.
	logic [2:0] pin_raw;
	logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
	assign pin_raw = {serial_rx_pin, frame_n_in, sclk_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_comb
			begin
				filt_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi] : filt_reg[gi];
			end
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					// Stages reset to the pin's idle level so that no false edge follows reset.
					sync1_reg[gi] <= (gi == 0) ? 1'b0 : 1'b1;
					sync2_reg[gi] <= (gi == 0) ? 1'b0 : 1'b1;
					sync3_reg[gi] <= (gi == 0) ? 1'b0 : 1'b1;
					filt_reg[gi] <= (gi == 0) ? 1'b0 : 1'b1;
				end
				else if (ce)
				begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					filt_reg[gi] <= filt_next[gi];
				end
			end
		end
	endgenerate

	// Register bus state.
	logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next, wdata_reg, wdata_next, strb_mask;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [15:0] ctrl0_reg, ctrl0_next;
	logic [3:0] ctrl1_reg, ctrl1_next;
	logic [7:0] presc_reg, presc_next;
	logic rd_take, wr_fire, link_busy;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	link_state_t state_reg, state_next;

	assign rd_take = s_axi_arvalid && arready_reg;
	assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
	assign link_busy = (state_reg != S_IDLE) || !tx_q.empty; // RQ22

	always_comb
	begin
		rd_resp = RESP_OKAY;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == CTRL0_OFF)
			rd_word = {16'h0000, ctrl0_reg};
		else if (s_axi_araddr == CTRL1_OFF)
			rd_word = {28'h000_0000, ctrl1_reg};
		else if (s_axi_araddr == DATA_OFF)
			rd_word = rx_q.empty ? 32'h0000_0000 : {16'h0000, rx_q.rdata}; // RQ10
		else if (s_axi_araddr == STAT_OFF)
			rd_word = {27'h000_0000, link_busy, rx_q.full, !rx_q.empty, !tx_q.full, tx_q.empty};
		else if (s_axi_araddr == PRESC_OFF)
			rd_word = {24'h00_0000, presc_reg};
		else
			rd_resp = RESP_SLVERR;
	end

	always_comb
	begin
		awready_next = awready_reg;
		wready_next = wready_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl0_next = ctrl0_reg;
		ctrl1_next = ctrl1_reg;
		presc_next = presc_reg;
		tx_q.push = 1'b0;
		tx_q.wdata = wdata_reg[15:0];
		rx_q.pop = 1'b0;
		strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
			{8{s_axi_wstrb[0]}}};
		if (s_axi_awvalid && awready_reg)
		begin
			awready_next = 1'b0;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg)
		begin
			wready_next = 1'b0;
			wdata_next = s_axi_wdata & strb_mask;
		end
		if (wr_fire)
		begin
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			if (awaddr_reg == CTRL0_OFF)
				ctrl0_next = wdata_reg[15:0];
			else if (awaddr_reg == CTRL1_OFF)
				ctrl1_next = wdata_reg[3:0]; // RQ4 RQ6
			else if (awaddr_reg == DATA_OFF)
				tx_q.push = 1'b1; // RQ11 RQ20
			else if (awaddr_reg == PRESC_OFF)
				presc_next = {wdata_reg[7:1], 1'b0};
			else if (awaddr_reg != STAT_OFF)
				bresp_next = RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready)
		begin
			bvalid_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
		if (rd_take)
		begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = rd_resp;
			rx_q.pop = (s_axi_araddr == DATA_OFF); // RQ10
		end
		if (rvalid_reg && s_axi_rready)
		begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			ctrl0_reg <= CTRL0_RST;
			ctrl1_reg <= CTRL1_RST;
			presc_reg <= PRESC_RST;
		end
		else if (ce)
		begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			presc_reg <= presc_next;
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// Serial link. Only clock polarity and phase zero are served by this shifter.
	logic enable, role, slave_out_disable, loop_sel, three_wire, rx_bit, rise_evt, fall_evt, tick;
	logic [4:0] word_len, tx_len, rx_start, total_len, cnt_reg, cnt_next;
	logic [15:0] tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next, half_period, div_reg;
	logic [15:0] div_next;
	logic [6:0] presc_half;
	logic sclk_reg, sclk_next, frame_n_reg, frame_n_next, tx_out_reg, tx_out_next;
	logic tx_oe_reg, tx_oe_next, pin_oe_reg, pin_oe_next, start;
	assign enable = ctrl1_reg[ENABLE_BIT];
	assign role = ctrl1_reg[ROLE_BIT]; // RQ4
	assign slave_out_disable = ctrl1_reg[SOD_BIT];
	assign loop_sel = ctrl1_reg[LOOP_BIT];
	assign three_wire = (ctrl0_reg[FRF_LSB +: 2] == FRF_THREE_WIRE);
	// Reserved small sizes fall back to the smallest legal size.
	assign word_len = (ctrl0_reg[DSS_LSB +: 4] < DSS_MIN) ? 5'd4
		: {1'b0, ctrl0_reg[DSS_LSB +: 4]} + 5'd1;
	assign tx_len = three_wire ? 5'(CMD_BITS) : word_len; // RQ17
	assign rx_start = three_wire ? 5'(CMD_BITS) : 5'd0;
	assign total_len = rx_start + word_len; // RQ18
	// A zero divisor would stall the master, so it is treated as the minimum of two.
	assign presc_half = (presc_reg[7:1] == 7'h00) ? 7'h01 : presc_reg[7:1];
	assign half_period = 16'(presc_half) * (16'(ctrl0_reg[SCR_LSB +: 8]) + 16'd1); // RQ21
	assign tick = !role && (div_reg == half_period - 16'd1);
	assign rx_bit = loop_sel ? tx_out_reg : filt_reg[2]; // RQ8

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		tx_shift_next = tx_shift_reg;
		rx_shift_next = rx_shift_reg;
		div_next = 16'h0000;
		sclk_next = sclk_reg;
		tx_q.pop = 1'b0;
		rx_q.push = 1'b0;
		rx_q.wdata = rx_shift_reg; // RQ16
		rise_evt = role ? (!filt_reg[0] && filt_next[0]) : (tick && !sclk_reg);
		fall_evt = role ? (filt_reg[0] && !filt_next[0]) : (tick && sclk_reg);
		// The master waits for receive room so that no received word is lost.
		start = role ? (filt_reg[1] && !filt_next[1]) : (!tx_q.empty && !rx_q.full);
		case (state_reg)
			S_IDLE:
			begin
				sclk_next = 1'b0;
				if (enable && start) // RQ23
				begin
					state_next = S_SHIFT;
					cnt_next = 5'd0;
					rx_shift_next = 16'h0000;
					tx_q.pop = 1'b1; // RQ13
					tx_shift_next = tx_q.empty ? 16'h0000 : tx_q.rdata << (5'd16 - tx_len); // RQ14
				end
			end
			S_SHIFT:
			begin
				div_next = tick ? 16'h0000 : div_reg + 16'd1;
				if (tick)
					sclk_next = !sclk_reg;
				if (rise_evt && cnt_reg >= rx_start)
					rx_shift_next = {rx_shift_reg[14:0], rx_bit};
				if (fall_evt)
				begin
					if (cnt_reg == total_len - 5'd1)
					begin
						state_next = S_IDLE;
						rx_q.push = 1'b1; // RQ12
					end
					else
					begin
						cnt_next = cnt_reg + 5'd1;
						tx_shift_next = {tx_shift_reg[14:0], 1'b0};
					end
				end
				if (!enable || (role && filt_next[1])) // RQ6 RQ23
				begin
					// A cut frame is dropped, never pushed half received.
					state_next = S_IDLE;
					rx_q.push = 1'b0;
				end
			end
			default: state_next = S_IDLE;
		endcase
		tx_out_next = tx_shift_next[15];
		tx_oe_next = (state_next == S_SHIFT) && (cnt_next < tx_len) && (!role || !slave_out_disable); // RQ1 RQ2 RQ3
		frame_n_next = !(state_next == S_SHIFT && !role);
		pin_oe_next = enable && !role;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= S_IDLE;
			cnt_reg <= 5'd0;
			tx_shift_reg <= 16'h0000;
			rx_shift_reg <= 16'h0000;
			div_reg <= 16'h0000;
			sclk_reg <= 1'b0;
			frame_n_reg <= 1'b1;
			tx_out_reg <= 1'b0;
			tx_oe_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			tx_shift_reg <= tx_shift_next;
			rx_shift_reg <= rx_shift_next;
			div_reg <= div_next;
			sclk_reg <= sclk_next;
			frame_n_reg <= frame_n_next;
			tx_out_reg <= tx_out_next;
			tx_oe_reg <= tx_oe_next;
			pin_oe_reg <= pin_oe_next;
		end
	end
	assign sclk_out = sclk_reg;
	assign sclk_oe = pin_oe_reg;
	assign frame_n_out = frame_n_reg;
	assign frame_oe = pin_oe_reg;
	assign serial_tx_pin_out = tx_out_reg;
	assign serial_tx_pin_oe = tx_oe_reg;

	property p_sod_quiet; // RQ2
		@(posedge aclk) disable iff (!aresetn) (ce && role && slave_out_disable) |=> !serial_tx_pin_oe;
	endproperty
	a_sod_quiet: assert property (p_sod_quiet) else $error("slave drove tx with output disabled"); // RQ2
	property p_master_drives; // RQ1
		@(posedge aclk) disable iff (!aresetn)
			(ce && !role && state_reg == S_SHIFT && state_next == S_SHIFT && cnt_next < tx_len)
			|=> serial_tx_pin_oe;
	endproperty
	a_master_drives: assert property (p_master_drives) else $error("master tx not driven"); // RQ1
	property p_slave_drives; // RQ3
		@(posedge aclk) disable iff (!aresetn)
			(ce && role && !slave_out_disable && state_next == S_SHIFT && cnt_next < tx_len) |=> serial_tx_pin_oe;
	endproperty
	a_slave_drives: assert property (p_slave_drives) else $error("slave tx not driven"); // RQ3
	property p_disabled_idle; // RQ23
		@(posedge aclk) disable iff (!aresetn) (ce && !enable) |=> state_reg == S_IDLE;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("shifter active while off"); // RQ23
	property p_read_pops; // RQ10
		@(posedge aclk) disable iff (!aresetn)
			(ce && rd_take && s_axi_araddr == DATA_OFF && !rx_q.empty && !rx_q.push)
			|=> rx_q.count == $past(rx_q.count) - (AW+1)'(1);
	endproperty
	a_read_pops: assert property (p_read_pops) else $error("data read did not pop"); // RQ10
	property p_write_pushes; // RQ11
		@(posedge aclk) disable iff (!aresetn)
			(ce && wr_fire && awaddr_reg == DATA_OFF && !tx_q.full && !tx_q.pop)
			|=> tx_q.count == $past(tx_q.count) + (AW+1)'(1);
	endproperty
	a_write_pushes: assert property (p_write_pushes) else $error("data write did not push"); // RQ11
	property p_no_flush; // RQ19
		@(posedge aclk) disable iff (!aresetn)
			(ce && !enable && !tx_q.push && !rx_q.pop) |=> $stable(tx_q.count) && $stable(rx_q.count);
	endproperty
	a_no_flush: assert property (p_no_flush) else $error("FIFO changed while disabled"); // RQ19
	property p_busy_read; // RQ22
		@(posedge aclk) disable iff (!aresetn)
			(ce && rd_take && s_axi_araddr == STAT_OFF && link_busy) |=> s_axi_rdata[ST_BSY];
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy not reported"); // RQ22
	property p_half_period; // RQ21
		@(posedge aclk) disable iff (!aresetn)
			(ce && !role && state_reg == S_SHIFT && div_reg > half_period) |-> 1'b0;
	endproperty
	a_half_period: assert property (p_half_period) else $error("divider overran half period"); // RQ21
endmodule
`default_nettype wire

// ==== test/serial_peer.sv ====
// Far-side serial device model: answers as a slave and can run frames as a master.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	input wire logic sclk_out,
	input wire logic frame_n_out,
	input wire logic tx_out,
	output logic sclk_in,
	output logic frame_n_in,
	output logic rx_pin
);
	logic [15:0] reply = 16'hFFFF;
	logic [15:0] sh = 16'h0000;
	logic [15:0] cap = 16'h0000;
	logic mst = 1'b0;
	initial
	begin
		sclk_in = 1'b0;
		frame_n_in = 1'b1;
		rx_pin = 1'b0;
	end
	always @(negedge frame_n_out)
	begin
		cap = 16'h0000;
		sh = reply;
		if (!mst)
			rx_pin = sh[15];
	end
	// A released line has no pull, so it shows the inverse of its last value.
	always @(posedge frame_n_out)
		if (!mst)
			rx_pin = ~rx_pin;
	always @(posedge sclk_out)
		if (!frame_n_out)
			cap = {cap[14:0], tx_out};
	always @(negedge sclk_out)
		if (!frame_n_out && !mst)
		begin
			sh = {sh[14:0], 1'b1};
			rx_pin = sh[15];
		end
	// Master frame, mode 0: data set while the clock is low, clock still outside the frame.
	task automatic run(input int n, input logic [15:0] w);
		int i;
		#5;
		mst = 1'b1;
		frame_n_in = 1'b0;
		for (i = n - 1; i >= 0; i--)
		begin
			rx_pin = w[i];
			#100 sclk_in = 1'b1;
			#100 sclk_in = 1'b0;
		end
		#200 frame_n_in = 1'b1;
		rx_pin = ~rx_pin;
		mst = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== test/test_sync_serial_ctrl_data_path.sv ====
// Self-checking bench for the serial port control and data path.
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_ctrl_data_path;
	import ssp_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic sclk_in, sclk_out, sclk_oe, frame_n_in, frame_n_out, frame_oe;
	logic rx_pin, tx_out, tx_oe;
	logic oe_seen = 1'b0;
	int n_fail = 0;
	int samples_checked = 0;
	ssp_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.frame_n_in(frame_n_in), .frame_n_out(frame_n_out), .frame_oe(frame_oe),
		.serial_rx_pin(rx_pin), .serial_tx_pin_out(tx_out), .serial_tx_pin_oe(tx_oe));
	serial_peer peer (.sclk_out(sclk_out), .frame_n_out(frame_n_out), .tx_out(tx_out),
		.sclk_in(sclk_in), .frame_n_in(frame_n_in), .rx_pin(rx_pin));
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (tx_oe)
			oe_seen = 1'b1;
	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic expire(input int i);
		if (i >= 2000)
		begin
			n_fail++;
			$display("[ERR] wait expected 1 seen 0");
			close_out();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic ad, wd;
		@(posedge aclk);
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 2000 && !(ad && wd); i++)
		begin
			@(posedge aclk);
			if (!ad && awready)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		expire(i);
		for (i = 0; i < 2000 && !bvalid; i++)
			@(posedge aclk);
		expire(i);
		if (!bvalid)
			@(posedge aclk);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 2000; i++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		expire(i);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, d, exp);
		chk("rresp", {30'h0, r}, {30'h0, (a > PRESC_OFF) ? RESP_SLVERR : RESP_OKAY});
	endtask
	task automatic wait_rx;
		int i;
		logic [31:0] d;
		logic [1:0] r;
		d = '0;
		for (i = 0; i < 2000 && !d[ST_RNE]; i += 20)
			rd(STAT_OFF, d, r);
		expire(i);
	endtask
	task automatic sc_regs;
		rchk("ctrl1 reset", CTRL1_OFF, 32'h0000_0000);
		rchk("empty rx", DATA_OFF, 32'h0000_0000);
		wr(CTRL1_OFF, 32'h0000_000D, RESP_OKAY);
		rchk("ctrl1", CTRL1_OFF, 32'h0000_000D);
		wr(CTRL1_OFF, 32'h0000_0000, RESP_OKAY);
		wr(12'h040, 32'h0000_0001, RESP_SLVERR);
		rchk("unmapped", 12'h040, 32'h0000_0000);
	endtask
	task automatic sc_loop;
		logic [31:0] d;
		logic [1:0] r;
		wr(PRESC_OFF, 32'h0000_0002, RESP_OKAY);
		wr(CTRL0_OFF, 32'h0000_0007, RESP_OKAY);
		wr(DATA_OFF, 32'h0000_FFA5, RESP_OKAY);
		rd(STAT_OFF, d, r);
		chk("busy", {31'h0, d[ST_BSY]}, 32'h1);
		chk("idle oe", {31'h0, sclk_oe}, 32'h0);
		oe_seen = 1'b0;
		wr(CTRL1_OFF, 32'h0000_000B, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("master clk oe", {31'h0, sclk_oe}, 32'h1);
		chk("master frame oe", {31'h0, frame_oe}, 32'h1);
		wait_rx();
		wr(CTRL1_OFF, 32'h0000_0000, RESP_OKAY);
		rchk("loopback word", DATA_OFF, 32'h0000_00A5);
		chk("master tx oe", {31'h0, oe_seen}, 32'h1);
		rchk("popped", DATA_OFF, 32'h0000_0000);
	endtask
	task automatic sc_slave(input logic slave_out_disable, input logic exp_oe);
		wr(CTRL0_OFF, 32'h0000_0003, RESP_OKAY);
		wr(CTRL1_OFF, {28'h0, slave_out_disable, 3'b100}, RESP_OKAY);
		wr(CTRL1_OFF, {28'h0, slave_out_disable, 3'b110}, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("slave clk oe", {31'h0, sclk_oe}, 32'h0);
		oe_seen = 1'b0;
		peer.run(4, 16'h000A);
		wait_rx();
		chk("slave tx oe", {31'h0, oe_seen}, {31'h0, exp_oe});
		wr(CTRL1_OFF, 32'h0000_0000, RESP_OKAY);
		rchk("slave word", DATA_OFF, 32'h0000_000A);
	endtask
	task automatic sc_off;
		logic [31:0] d;
		logic [1:0] r;
		wr(CTRL1_OFF, 32'h0000_0004, RESP_OKAY);
		oe_seen = 1'b0;
		peer.run(4, 16'h0005);
		repeat (20) @(posedge aclk);
		rd(STAT_OFF, d, r);
		chk("disabled rx", {31'h0, d[ST_RNE]}, 32'h0);
		chk("disabled oe", {31'h0, oe_seen}, 32'h0);
		wr(CTRL1_OFF, 32'h0000_0000, RESP_OKAY);
	endtask
	task automatic sc_three;
		wr(CTRL0_OFF, {24'h0, 2'b00, FRF_THREE_WIRE, 4'h3}, RESP_OKAY);
		wr(DATA_OFF, 32'h0000_12C3, RESP_OKAY);
		wr(CTRL1_OFF, 32'h0000_0002, RESP_OKAY);
		wait_rx();
		wr(CTRL1_OFF, 32'h0000_0000, RESP_OKAY);
		chk("three-wire tx", {24'h0, peer.cap[11:4]}, 32'h0000_00C3);
		rchk("three-wire rx", DATA_OFF, 32'h0000_000F);
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		sc_regs();
		sc_loop();
		sc_slave(1'b1, 1'b0);
		sc_slave(1'b0, 1'b1);
		sc_off();
		sc_three();
		close_out();
	end
endmodule
`default_nettype wire
